// ===== mgr_consts.svh
// -----------------------------------------------------------------------------
// How it works
// -----------------------------------------------------------------------------
`ifndef MGR_CONSTS_SVH
`define MGR_CONSTS_SVH
// printed offsets are indices, byte address is four times
`define MGR_IDX_PHY_ADDR 8'h19
`define MGR_IDX_MED_STAT 8'h1a
`define MGR_IDX_MED_MODE 8'h1b
`define MGR_IDX_MON_STAT 8'h1c
`define MGR_IDX_MON_CTRL 8'h1d
`define MGR_IDX_PIN_STAT 8'h1e
`define MGR_IDX_PIN_CTRL 8'h1f
`define MGR_IDX_SRST 8'h20
`define MGR_EE_PHY_WORD 8'h11
// reset values
`define MGR_MED_RESET 16'h0236
`define MGR_MON_RESET 8'h00
`define MGR_PIN_RESET 8'h00
`define MGR_SRST_RESET 8'h4c
`define MGR_CTRL_RESET 16'hf001
// writable bit masks; fixed bits are forced to what software must write
`define MGR_MED_WMASK 16'h1bb6
`define MGR_MED_FORCE1 16'h0004
`define MGR_MON_WMASK 8'h07
`define MGR_PIN_WMASK 8'hbf
`define MGR_SRST_WMASK 8'h7f
// medium mode field positions
`define MGR_MB_FD 1
`define MGR_MB_RFC 4
`define MGR_MB_TFC 5
`define MGR_MB_PF 7
`define MGR_MB_RE 8
`define MGR_MB_PS 9
`define MGR_MB_SBP 11
`define MGR_MB_SM 12
// monitor positions
`define MGR_MON_MOM 0
`define MGR_MON_WAKE_ON_LINK_UP 1
`define MGR_MON_WAKE_ON_MAGIC_PACKET 2
`define MGR_MON_US 4
// pin control positions
`define MGR_PIN_RSE 7
// soft reset positions
`define MGR_SR_RR 0
`define MGR_SR_RT 1
`define MGR_SR_EXT_PHY_RESET_TRISTATE 2
`define MGR_SR_PRL 3
`define MGR_SR_BZ 4
`define MGR_SR_INTERNAL_PHY_RESET_N 5
`define MGR_SR_INTERNAL_PHY_POWERDOWN 6
`endif

// ===== mgr_pkg.sv
package mgr_pkg;
    // eeprom-loaded phy identity
    typedef struct packed {
        logic [2:0] secondary_phy_type;
        logic [4:0] secondary_phy_addr;
        logic [2:0] primary_phy_type;
        logic [4:0] primary_phy_addr;
    } mgr_phy_s;
    // mac-facing controls
    typedef struct packed {
        logic port_speed;
        logic full_duplex;
        logic rx_pause_accept;
        logic tx_pause_send;
        logic pause_by_type_only;
        logic rx_path_on;
        logic continuous_backpressure;
        logic fast_backoff_enable;
        logic monitor_only;
        logic wake_on_link_up;
        logic wake_on_magic_packet;
        logic force_zero_length_in;
        logic bulk_in_length_fault_clear;
        logic bulk_out_length_fault_clear;
        logic internal_phy_reset_n;
        logic internal_phy_powerdown;
    } mgr_ctrl_s;
    // three pins, each with an output and an enable
    typedef struct packed {
        logic [2:0] out;
        logic [2:0] oe;
    } mgr_pins_s;
    typedef enum logic [2:0] {
        MGR_IDLE = 3'b001,
        MGR_ACCESS = 3'b010,
        MGR_DONE = 3'b100
    } mgr_state_e;
endpackage

// ===== mgr_regs.sv
`timescale 1ns/10ps
`default_nettype none
`include "mgr_consts.svh"
module mgr_regs (
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // eeprom loader side
    input wire logic eeLoadValid,
    input wire logic [7:0] eeLoadWord,
    input wire logic [15:0] eeLoadData,
    input wire logic eeprom_phy_reset_select,
    output logic eeprom_reload,
    // status sources
    input wire logic host_link_high_speed,
    input wire logic usbReset,
    input wire logic bulkInFaultEvent,
    input wire logic bulkOutFaultEvent,
    output logic bulkInFault,
    output logic bulkOutFault,
    // controls toward mac and phy
    output mgr_pkg::mgr_ctrl_s ctrl,
    output mgr_pkg::mgr_phy_s phyInfo,
    // general purpose pins
    input wire logic [2:0] gpioIn,
    output mgr_pkg::mgr_pins_s gpio,
    // external phy reset pin
    output logic ext_phy_reset_pin_out,
    output logic ext_phy_reset_pin_oe
);
    import mgr_pkg::*;

    // -------------------------------------------------------------------------
    // bus decode
    // -------------------------------------------------------------------------
    logic [15:0] medMode;
    logic [7:0] monCtrl;
    logic [7:0] pinCtrl;
    logic [7:0] softRst;
    logic [2:0] gpioMeta;
    logic [2:0] gpioSync;
    mgr_state_e state;
    mgr_state_e next_state;

    // word index from the byte address, low bits ignored
    wire [7:0] regIdx = paddr[9:2];
    wire setupPhase = psel && !penable;
    wire accessTake = (state == MGR_ACCESS);
    wire doWrite = accessTake && pwrite;
    wire isMode = (regIdx == `MGR_IDX_MED_MODE);
    wire isMon = (regIdx == `MGR_IDX_MON_CTRL);
    wire isPin = (regIdx == `MGR_IDX_PIN_CTRL);
    wire isSrst = (regIdx == `MGR_IDX_SRST);
    wire isRead = (regIdx == `MGR_IDX_PHY_ADDR) || (regIdx == `MGR_IDX_MED_STAT)
        || (regIdx == `MGR_IDX_MON_STAT) || (regIdx == `MGR_IDX_PIN_STAT);
    // write-only slots reject reads, read-only slots reject writes
    wire mapped = pwrite ? (isMode || isMon || isPin || isSrst) : isRead;
    wire badAddr = !mapped || (paddr[11:10] != 2'b00);

    // byte-lane merge used by every writable register
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] s);
        merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction

    // -------------------------------------------------------------------------
    // read data
    // -------------------------------------------------------------------------
    wire [7:0] monStat = {3'b000, host_link_high_speed, 1'b0, monCtrl[2:0]};
    wire [7:0] pinStat = {2'b00, gpioSync[2], pinCtrl[4], gpioSync[1], pinCtrl[2],
                          gpioSync[0], pinCtrl[0]};
    wire [15:0] rdSel =
        (regIdx == `MGR_IDX_PHY_ADDR) ? phyInfo :
        (regIdx == `MGR_IDX_MED_STAT) ? medMode :
        (regIdx == `MGR_IDX_MON_STAT) ? {8'h00, monStat} :
        (regIdx == `MGR_IDX_PIN_STAT) ? {8'h00, pinStat} : 16'h0000;

    // -------------------------------------------------------------------------
    // apb handshake: one wait cycle, answer on the second access edge
    // -------------------------------------------------------------------------
    // setup seen in idle moves to access; the access edge lands writes and
    // registers the answer, so pready stands for the one cycle after it;
    // done lets psel fall before idle looks again, at no cost to a master
    always_comb begin
        case (state)
            MGR_IDLE: next_state = setupPhase ? MGR_ACCESS : MGR_IDLE;
            MGR_ACCESS: next_state = MGR_DONE;
            MGR_DONE: next_state = MGR_IDLE;
            default: next_state = MGR_IDLE;
        endcase
    end

    // state and answer registers
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state <= MGR_IDLE;
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            state <= next_state;
            pready <= accessTake;
            pslverr <= accessTake && badAddr;
            prdata <= (accessTake && !pwrite && !badAddr) ? {16'h0000, rdSel} : 32'h00000000;
        end
    end

    // -------------------------------------------------------------------------
    // writable registers
    // -------------------------------------------------------------------------
    // writes land on the edge where pready is raised; defaults on reset
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            medMode <= `MGR_MED_RESET;
            monCtrl <= `MGR_MON_RESET;
            pinCtrl <= `MGR_PIN_RESET;
            softRst <= `MGR_SRST_RESET;
        end else if (doWrite && !badAddr) begin
            // fixed bits kept as software is told to write them (1 at bit 2)
            if (isMode) medMode <= (merge16(medMode, pwdata, pstrb) & `MGR_MED_WMASK)
                                   | `MGR_MED_FORCE1;
            if (isMon) monCtrl <= 8'(merge16({8'h00, monCtrl}, pwdata, pstrb)) & `MGR_MON_WMASK;
            if (isPin) pinCtrl <= 8'(merge16({8'h00, pinCtrl}, pwdata, pstrb)) & `MGR_PIN_WMASK;
            if (isSrst) softRst <= 8'(merge16({8'h00, softRst}, pwdata, pstrb)) & `MGR_SRST_WMASK;
        end else begin
            pinCtrl[`MGR_PIN_RSE] <= 1'b0; // reload is a request, cleared after one cycle
        end
    end

    // -------------------------------------------------------------------------
    // eeprom phy bytes and pin sampling
    // -------------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            phyInfo <= '0;
            gpioMeta <= 3'b000;
            gpioSync <= 3'b000;
        end else begin
            if (eeLoadValid && eeLoadWord == `MGR_EE_PHY_WORD) phyInfo <= eeLoadData;
            gpioMeta <= gpioIn;
            gpioSync <= gpioMeta;
        end
    end

    // -------------------------------------------------------------------------
    // length faults: event sets unless clear bit holds them off
    // -------------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            bulkInFault <= 1'b0;
            bulkOutFault <= 1'b0;
        end else begin
            bulkInFault <= !softRst[`MGR_SR_RR] && (bulkInFault || bulkInFaultEvent);
            bulkOutFault <= !softRst[`MGR_SR_RT] && (bulkOutFault || bulkOutFaultEvent);
        end
    end

    // -------------------------------------------------------------------------
    // registered outputs toward mac, phy and pins
    // -------------------------------------------------------------------------
    wire extRstLevel = eeprom_phy_reset_select ? softRst[`MGR_SR_PRL] : !usbReset;
    // sampled select flag may follow reset, so internal_phy_reset_n only gates when it is set
    wire iphyRunN = eeprom_phy_reset_select ? softRst[`MGR_SR_INTERNAL_PHY_RESET_N] : 1'b1;
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ctrl <= `MGR_CTRL_RESET;
            gpio <= '0;
            ext_phy_reset_pin_out <= 1'b1;
            ext_phy_reset_pin_oe <= 1'b0;
            eeprom_reload <= 1'b0;
        end else begin
            ctrl <= {medMode[`MGR_MB_PS], medMode[`MGR_MB_FD], medMode[`MGR_MB_RFC],
                     medMode[`MGR_MB_TFC], medMode[`MGR_MB_PF], medMode[`MGR_MB_RE],
                     medMode[`MGR_MB_SBP], medMode[`MGR_MB_SM],
                     monCtrl[`MGR_MON_MOM], monCtrl[`MGR_MON_WAKE_ON_LINK_UP],
                     monCtrl[`MGR_MON_WAKE_ON_MAGIC_PACKET], softRst[`MGR_SR_BZ],
                     softRst[`MGR_SR_RR], softRst[`MGR_SR_RT], iphyRunN,
                     softRst[`MGR_SR_INTERNAL_PHY_POWERDOWN]};
            gpio <= {pinCtrl[5], pinCtrl[3], pinCtrl[1], pinCtrl[4], pinCtrl[2], pinCtrl[0]};
            ext_phy_reset_pin_out <= extRstLevel;
            ext_phy_reset_pin_oe <= !softRst[`MGR_SR_EXT_PHY_RESET_TRISTATE];
            eeprom_reload <= pinCtrl[`MGR_PIN_RSE];
        end
    end

    // -------------------------------------------------------------------------
    // checks
    // -------------------------------------------------------------------------
    a_pready_timing: assert property (@(posedge sys_clk) disable iff (!nrst)
        setupPhase && state == MGR_IDLE |-> ##2 pready) else $error("late pready");
    a_readback_mode: assert property (@(posedge sys_clk) disable iff (!nrst)
        doWrite && isMode && !badAddr && pstrb[1] |=> medMode[9] == $past(pwdata[9]))
        else $error("mode not stored");
    a_speed_follow: assert property (@(posedge sys_clk) disable iff (!nrst)
        ##1 ctrl.port_speed == $past(medMode[`MGR_MB_PS])) else $error("speed lag");
    a_duplex_follow: assert property (@(posedge sys_clk) disable iff (!nrst)
        ##1 ctrl.full_duplex == $past(medMode[`MGR_MB_FD])) else $error("duplex lag");
    a_rx_enable: assert property (@(posedge sys_clk) disable iff (!nrst)
        ##1 ctrl.rx_path_on == $past(medMode[`MGR_MB_RE])) else $error("rx enable lag");
    a_gpio_oe: assert property (@(posedge sys_clk) disable iff (!nrst)
        ##1 gpio.oe == $past({pinCtrl[4], pinCtrl[2], pinCtrl[0]})) else $error("gpio oe");
    a_fault_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
        softRst[`MGR_SR_RR] |=> !bulkInFault) else $error("fault not held");
    a_ext_float: assert property (@(posedge sys_clk) disable iff (!nrst)
        softRst[`MGR_SR_EXT_PHY_RESET_TRISTATE] |=> !ext_phy_reset_pin_oe) else $error("pin driven");
    a_ext_level: assert property (@(posedge sys_clk) disable iff (!nrst)
        eeprom_phy_reset_select && !softRst[`MGR_SR_EXT_PHY_RESET_TRISTATE] |=>
        ext_phy_reset_pin_out == $past(softRst[`MGR_SR_PRL])) else $error("pin level");
    a_powerdown: assert property (@(posedge sys_clk) disable iff (!nrst)
        ##1 ctrl.internal_phy_powerdown == $past(softRst[`MGR_SR_INTERNAL_PHY_POWERDOWN])) else $error("pd lag");

    // -------------------------------------------------------------------------
    // bus answer, fixed mode bit and phy load checks
    // -------------------------------------------------------------------------
    // a pready held longer would hand a waiting master a second answer
    a_pready_pulse: assert property (@(posedge sys_clk) disable iff (!nrst)
        pready
        |=> !pready)
        else $error("pready held");

    a_slverr_pair: assert property (@(posedge sys_clk) disable iff (!nrst)
        pslverr
        |-> pready)
        else $error("lone slverr");

    a_refused_data: assert property (@(posedge sys_clk) disable iff (!nrst)
        pslverr
        |-> prdata == 32'h00000000)
        else $error("refused data");

    a_upper_zero: assert property (@(posedge sys_clk) disable iff (!nrst)
        pready
        |-> prdata[31:16] == 16'h0000)
        else $error("upper bits");

    a_mode_fixed: assert property (@(posedge sys_clk) disable iff (!nrst)
        medMode[2]
        && ((medMode & ~`MGR_MED_WMASK) == 16'h0000))
        else $error("mode fixed bits");

    a_phy_load: assert property (@(posedge sys_clk) disable iff (!nrst)
        eeLoadValid && eeLoadWord == `MGR_EE_PHY_WORD
        |=> phyInfo == $past(eeLoadData))
        else $error("phy not loaded");

    a_phy_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
        !(eeLoadValid && eeLoadWord == `MGR_EE_PHY_WORD)
        |=> $stable(phyInfo))
        else $error("phy changed");

    a_usb_speed: assert property (@(posedge sys_clk) disable iff (!nrst)
        accessTake && !pwrite && regIdx == `MGR_IDX_MON_STAT && !badAddr
        |=> prdata[`MGR_MON_US] == $past(host_link_high_speed))
        else $error("speed status");

    a_pin_status: assert property (@(posedge sys_clk) disable iff (!nrst)
        accessTake && !pwrite && regIdx == `MGR_IDX_PIN_STAT && !badAddr
        |=> {prdata[4], prdata[2], prdata[0]} == $past(gpio.oe))
        else $error("pin status");

    // -------------------------------------------------------------------------
    // mac, pin and reset control checks
    // -------------------------------------------------------------------------
    a_pause_follow: assert property (@(posedge sys_clk) disable iff (!nrst)
        ##1 {ctrl.rx_pause_accept, ctrl.tx_pause_send, ctrl.pause_by_type_only}
        == $past({medMode[`MGR_MB_RFC], medMode[`MGR_MB_TFC], medMode[`MGR_MB_PF]}))
        else $error("pause lag");

    a_backoff_follow: assert property (@(posedge sys_clk) disable iff (!nrst)
        ##1 {ctrl.continuous_backpressure, ctrl.fast_backoff_enable}
        == $past({medMode[`MGR_MB_SBP], medMode[`MGR_MB_SM]}))
        else $error("backoff lag");

    a_monitor_follow: assert property (@(posedge sys_clk) disable iff (!nrst)
        ##1 {ctrl.monitor_only, ctrl.wake_on_link_up, ctrl.wake_on_magic_packet}
        == $past({monCtrl[`MGR_MON_MOM], monCtrl[`MGR_MON_WAKE_ON_LINK_UP], monCtrl[`MGR_MON_WAKE_ON_MAGIC_PACKET]}))
        else $error("monitor lag");

    a_gpio_out: assert property (@(posedge sys_clk) disable iff (!nrst)
        ##1 gpio.out
        == $past({pinCtrl[5], pinCtrl[3], pinCtrl[1]}))
        else $error("gpio out");

    a_reload_pulse: assert property (@(posedge sys_clk) disable iff (!nrst)
        eeprom_reload
        |=> !eeprom_reload)
        else $error("reload held");

    a_reload_req: assert property (@(posedge sys_clk) disable iff (!nrst)
        doWrite && isPin && !badAddr && pstrb[0] && pwdata[`MGR_PIN_RSE]
        |=> ##1 eeprom_reload)
        else $error("reload missing");

    a_fault_set: assert property (@(posedge sys_clk) disable iff (!nrst)
        !softRst[`MGR_SR_RR] && bulkInFaultEvent
        |=> bulkInFault)
        else $error("fault lost");

    a_fault_out: assert property (@(posedge sys_clk) disable iff (!nrst)
        softRst[`MGR_SR_RT]
        |=> !bulkOutFault)
        else $error("out fault held");

    a_clear_bits: assert property (@(posedge sys_clk) disable iff (!nrst)
        ##1 {ctrl.bulk_in_length_fault_clear, ctrl.bulk_out_length_fault_clear}
        == $past({softRst[`MGR_SR_RR], softRst[`MGR_SR_RT]}))
        else $error("clear lag");

    a_zero_len: assert property (@(posedge sys_clk) disable iff (!nrst)
        ##1 ctrl.force_zero_length_in
        == $past(softRst[`MGR_SR_BZ]))
        else $error("zero length lag");

    a_int_reset: assert property (@(posedge sys_clk) disable iff (!nrst)
        eeprom_phy_reset_select
        |=> ctrl.internal_phy_reset_n == $past(softRst[`MGR_SR_INTERNAL_PHY_RESET_N]))
        else $error("internal reset");

    a_ext_drive: assert property (@(posedge sys_clk) disable iff (!nrst)
        !softRst[`MGR_SR_EXT_PHY_RESET_TRISTATE]
        |=> ext_phy_reset_pin_oe)
        else $error("pin floated");

    a_ext_usb: assert property (@(posedge sys_clk) disable iff (!nrst)
        !eeprom_phy_reset_select && !softRst[`MGR_SR_EXT_PHY_RESET_TRISTATE]
        |=> ext_phy_reset_pin_out == !$past(usbReset))
        else $error("pin usb level");
endmodule // mgr_regs
`default_nettype wire

// ===== test_medium_gpio_reset_control_regs.sv
`timescale 1ns/10ps
`default_nettype none
`include "mgr_consts.svh"
module test_medium_gpio_reset_control_regs;
    import mgr_pkg::*;
    // -------------------------------------------------------------------------
    // bench signals
    // -------------------------------------------------------------------------
    logic sys_clk, nrst, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdata;
    logic [3:0] pstrb;
    logic eeLoadValid, eeprom_phy_reset_select, eeprom_reload, host_link_high_speed, usbReset;
    logic bulkInFaultEvent, bulkOutFaultEvent, bulkInFault, bulkOutFault, extOut, extOe;
    logic [7:0] eeLoadWord;
    logic [15:0] eeLoadData;
    logic [2:0] gpioIn;
    mgr_ctrl_s ctrl;
    mgr_phy_s phyInfo;
    mgr_pins_s gpio;
    int nErrors, comparisons;
    mgr_regs dut (.sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .eeLoadValid(eeLoadValid), .eeLoadWord(eeLoadWord),
        .eeLoadData(eeLoadData), .eeprom_phy_reset_select(eeprom_phy_reset_select),
        .eeprom_reload(eeprom_reload), .host_link_high_speed(host_link_high_speed),
        .usbReset(usbReset), .bulkInFaultEvent(bulkInFaultEvent),
        .bulkOutFaultEvent(bulkOutFaultEvent), .bulkInFault(bulkInFault),
        .bulkOutFault(bulkOutFault), .ctrl(ctrl), .phyInfo(phyInfo), .gpioIn(gpioIn),
        .gpio(gpio), .ext_phy_reset_pin_out(extOut), .ext_phy_reset_pin_oe(extOe));
    // 100 MHz clock
    initial sys_clk = 1'b0;
    always #5 sys_clk = ~sys_clk;
    // -------------------------------------------------------------------------
    // shared tasks
    // -------------------------------------------------------------------------
    function automatic logic [11:0] A(input logic [7:0] i);
        return {2'b00, i, 2'b00};
    endfunction
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            nErrors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one apb transfer; starts on a fresh edge so psel is never driven twice in a step
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        @(posedge sys_clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rdata = prdata;
        err = pslverr;
        chk("pready", 32'(pready), 32'h1);
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic results;
        if (nErrors == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // -------------------------------------------------------------------------
    // scenarios
    // -------------------------------------------------------------------------
    task automatic resetValues;
        mgr_ctrl_s e;
        e = '{port_speed:1'b1, full_duplex:1'b1, rx_pause_accept:1'b1, tx_pause_send:1'b1,
              internal_phy_powerdown:1'b1, default:1'b0};
        chk("ctrl", 32'(ctrl), 32'(e));
        chk("gpioOe", 32'(gpio.oe), 32'h0);
        chk("extOe", 32'(extOe), 32'h0);
        apb(1'b0, A(`MGR_IDX_MED_STAT), 32'h0);
        chk("medStat", rdata, 32'h0236);
        apb(1'b0, A(`MGR_IDX_PIN_STAT), 32'h0);
        chk("pinStat", rdata, 32'h0);
    endtask
    // both extremes of every medium field, the second also writing reserved bits as ones, then the reset value
    task automatic mediumMode;
        logic [15:0] v[3] = '{16'h1984, 16'he636, 16'h0236};
        logic [15:0] r[3] = '{16'h1984, 16'h0236, 16'h0236};
        logic [7:0] f[3] = '{8'h0f, 8'hf0, 8'hf0};
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, A(`MGR_IDX_MED_MODE), 32'(v[i]));
            chk("medErr", 32'(err), 32'h0);
            settle(3);
            chk("medCtrl", 32'(ctrl[15:8]), 32'(f[i]));
            apb(1'b0, A(`MGR_IDX_MED_STAT), 32'h0);
            chk("medStat", rdata, 32'(r[i]));
        end
    endtask
    task automatic monitor;
        apb(1'b1, A(`MGR_IDX_MON_CTRL), 32'hff);
        settle(3);
        chk("monCtrl", 32'({ctrl.monitor_only, ctrl.wake_on_link_up,
            ctrl.wake_on_magic_packet}), 32'h7);
        for (int s = 1; s >= 0; s--) begin
            host_link_high_speed <= s[0];
            apb(1'b0, A(`MGR_IDX_MON_STAT), 32'h0);
            chk("monStat", rdata, s[0] ? 32'h17 : 32'h07);
        end
    endtask
    task automatic pins;
        logic [31:0] cnt;
        gpioIn <= 3'b010;
        apb(1'b1, A(`MGR_IDX_PIN_CTRL), 32'h1b);
        settle(4);
        chk("gpioDrive", 32'({gpio.oe, gpio.out[2], gpio.out[0]}), 32'h15);
        apb(1'b0, A(`MGR_IDX_PIN_STAT), 32'h0);
        chk("pinStat", rdata, 32'h19);
        apb(1'b1, A(`MGR_IDX_PIN_CTRL), 32'h9b);
        cnt = 0;
        repeat (6) begin
            @(posedge sys_clk);
            cnt = cnt + 32'(eeprom_reload);
        end
        chk("reloadPulses", cnt, 32'h1);
    endtask
    task automatic pulseFaults;
        @(posedge sys_clk);
        bulkInFaultEvent <= 1'b1; bulkOutFaultEvent <= 1'b1;
        @(posedge sys_clk);
        bulkInFaultEvent <= 1'b0; bulkOutFaultEvent <= 1'b0;
        settle(3);
    endtask
    task automatic softReset;
        eeprom_phy_reset_select <= 1'b1;
        apb(1'b1, A(`MGR_IDX_SRST), 32'h00);
        settle(3);
        chk("extPin", 32'({extOe, extOut}), 32'h2);
        chk("intPhy", 32'({ctrl.internal_phy_reset_n, ctrl.internal_phy_powerdown}), 32'h0);
        apb(1'b1, A(`MGR_IDX_SRST), 32'h2b);
        pulseFaults();
        chk("extPin", 32'({extOe, extOut}), 32'h3);
        chk("intRst", 32'(ctrl.internal_phy_reset_n), 32'h1);
        chk("faultHeld", 32'({bulkInFault, bulkOutFault}), 32'h0);
        chk("clearBits", 32'({ctrl.bulk_in_length_fault_clear,
            ctrl.bulk_out_length_fault_clear}), 32'h3);
        apb(1'b1, A(`MGR_IDX_SRST), 32'h10);
        settle(3);
        chk("zeroLen", 32'(ctrl.force_zero_length_in), 32'h1);
        chk("faultIdle", 32'({bulkInFault, bulkOutFault}), 32'h0);
        pulseFaults();
        chk("faultSet", 32'({bulkInFault, bulkOutFault}), 32'h3);
        eeprom_phy_reset_select <= 1'b0;
        usbReset <= 1'b1;
        settle(3);
        chk("extUsbRst", 32'({extOe, extOut}), 32'h2);
        apb(1'b1, A(`MGR_IDX_SRST), 32'h44);
        settle(3);
        chk("extFloat", 32'({extOe, ctrl.internal_phy_powerdown}), 32'h1);
    endtask
    // phy bytes load only from their own word and ignore a load on the word before
    task automatic phyLoad;
        logic [15:0] d[2] = '{16'hffff, 16'ha5c3};
        for (int i = 0; i < 2; i++) begin
            @(posedge sys_clk);
            eeLoadValid <= 1'b1; eeLoadWord <= `MGR_EE_PHY_WORD - 8'(1 - i); eeLoadData <= d[i];
            @(posedge sys_clk);
            eeLoadValid <= 1'b0;
            apb(1'b0, A(`MGR_IDX_PHY_ADDR), 32'h0);
            chk("phyRead", rdata, i ? 32'ha5c3 : 32'h0);
        end
        chk("phyInfo", 32'(phyInfo), 32'ha5c3);
    endtask
    // a reset in mid-run puts every register back to its default
    task automatic midReset;
        gpioIn <= 3'b000;
        @(posedge sys_clk);
        nrst <= 1'b0;
        settle(2);
        nrst <= 1'b1;
        chk("phyReset", 32'(phyInfo), 32'h0);
        resetValues();
        apb(1'b0, A(`MGR_IDX_MON_STAT), 32'h0);
        chk("monReset", rdata, 32'h0);
    endtask
    task automatic refusals;
        logic [11:0] a[5] = '{A(`MGR_IDX_MED_MODE), A(`MGR_IDX_MED_STAT), A(8'h21), 12'h468,
                              A(`MGR_IDX_PHY_ADDR)};
        logic w[5] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
        for (int i = 0; i < 5; i++) begin
            apb(w[i], a[i], 32'hffff);
            chk("refusedErr", 32'(err), 32'h1);
            chk("refusedData", rdata, 32'h0);
        end
        apb(1'b0, A(`MGR_IDX_MED_STAT), 32'h0);
        chk("medKept", rdata, 32'h0236);
    endtask
    // -------------------------------------------------------------------------
    // main sequence and watchdog
    // -------------------------------------------------------------------------
    initial begin
        nErrors = 0; comparisons = 0;
        nrst = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0;
        pwdata = '0; pstrb = 4'h3; eeLoadValid = 1'b0; eeLoadWord = '0; eeLoadData = '0;
        eeprom_phy_reset_select = 1'b0; host_link_high_speed = 1'b1; usbReset = 1'b0;
        bulkInFaultEvent = 1'b0; bulkOutFaultEvent = 1'b0; gpioIn = 3'b000;
        settle(10);
        nrst <= 1'b1;
        resetValues();
        mediumMode();
        monitor();
        pins();
        softReset();
        phyLoad();
        midReset();
        refusals();
        results();
    end
    // whole run is well under a thousand cycles
    initial begin
        settle(5000);
        nErrors++;
        results();
    end
endmodule // test_medium_gpio_reset_control_regs
`default_nettype wire
